// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  import rsba_pkg::*;

  // Short copy period keeps the second-copy test quick
  localparam int COPY2_SIM = 20;
  logic clk;
  logic rst_b;
  rsba_bus_type bus;
  rsba_sample_type sample;
  logic [7:0] rdata;
  logic irq_b;
  int err_count;
  int checks;
  int cyc;

  rsba_top #(.COPY2_CYC(COPY2_SIM)) u_rsba_top (
    .clk(clk),
    .rst_b(rst_b),
    .bus(bus),
    .rdata(rdata),
    .sample(sample),
    .irq_b(irq_b)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hung busy poll must not stall the run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_raw(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_raw(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask

  // Poll busy; the access must last about 650 ns at 4 ns per cycle
  task automatic wait_idle(input int t0);
    logic [7:0] d;
    int n;
    n = 0;
    do begin
      rd_raw(RSBA_OFS_1, d);
      n++;
    end while (d[RSBA_BUSY_BIT] !== 1'b0 && n < 200);
    check("busy span ok", 8'((cyc - t0) >= 160 && (cyc - t0) <= 168),
          8'h01);
  endtask

  task automatic ind_rd(input logic [6:0] a, input logic [7:0] exp);
    int t0;
    wr(RSBA_OFS_2, {1'b1, a});
    t0 = cyc;
    wait_idle(t0);
    rd(RSBA_OFS_3, exp);
  endtask

  task automatic samp(input logic [4:0] ch, input logic [3:0] abcd);
    @(posedge clk);
    sample <= '{valid: 1'b1, chan: ch, abcd: abcd};
    @(posedge clk);
    sample.valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int t0;
    rst_b = 1'b0;
    bus = '0;
    sample = '0;
    err_count = 0;
    checks = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;

    rd(RSBA_OFS_CONFIG, 8'h00);
    rd(RSBA_OFS_1, 8'h00);
    rd(RSBA_OFS_2, 8'h00);
    rd(8'h44, 8'h00);
    wr(RSBA_OFS_CONFIG, 8'hFF);
    rd(RSBA_OFS_CONFIG, 8'h65);
    $display("test reset and config done");

    // EXTENDED_SUPERFRAME_SELECT with per-channel functions on, access-port view
    wr(RSBA_OFS_CONFIG, 8'h05);
    wr(RSBA_OFS_3, 8'h01);
    wr(RSBA_OFS_2, 8'h41);
    t0 = cyc;
    rd(RSBA_OFS_1, 8'h80);
    wr(RSBA_OFS_3, 8'h55);
    wr(RSBA_OFS_2, 8'hC5);
    wait_idle(t0);
    rd(RSBA_OFS_2, 8'h41);
    rd(RSBA_OFS_3, 8'h01);
    wr(RSBA_OFS_3, 8'h00);
    ind_rd(7'h41, 8'h01);
    ind_rd(7'h19, 8'h00);
    $display("test indirect access done");

    // Change view with interrupt enabled; ch1 debounced
    wr(RSBA_OFS_CONFIG, 8'h65);
    samp(5'd1, 4'hA);
    rd(RSBA_OFS_3, 8'h00);
    check("irq idle", {7'h00, irq_b}, 8'h01);
    samp(5'd1, 4'hA);
    repeat (2) @(posedge clk);
    #1;
    check("irq set", {7'h00, irq_b}, 8'h00);
    rd(RSBA_OFS_3, 8'h01);
    rd(RSBA_OFS_3, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check("irq clear", {7'h00, irq_b}, 8'h01);
    samp(5'd24, 4'h3);
    samp(5'd17, 4'h3);
    samp(5'd9, 4'h3);
    samp(5'd8, 4'h3);
    wr(RSBA_OFS_2, 8'h00);
    rd(RSBA_OFS_1, 8'h81);
    rd(RSBA_OFS_2, 8'h01);
    rd(RSBA_OFS_3, 8'h80);
    rd(RSBA_OFS_1, 8'h00);
    $display("test change flags done");

    // Superframe: C,D repeat A,B
    wr(RSBA_OFS_CONFIG, 8'h01);
    rd(RSBA_OFS_2, 8'h99);
    samp(5'd2, 4'h4);
    ind_rd(7'h02, 8'h05);
    ind_rd(7'h18, 8'h03);
    ind_rd(7'h01, 8'h0A);
    ind_rd(7'h21, 8'h0A);
    ind_rd(7'h38, 8'h03);
    // Per-channel functions off: debounce on ch1 must not hold a sample
    wr(RSBA_OFS_CONFIG, 8'h00);
    samp(5'd1, 4'h4);
    ind_rd(7'h01, 8'h05);
    $display("test signaling data done");
    conclude();
  end

endmodule // tb

`default_nettype wire

// ===== verilog/rsba_pkg.sv
package rsba_pkg;

  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] RSBA_OFS_CONFIG = 8'h40;
  localparam logic [7:0] RSBA_OFS_1 = 8'h41;
  localparam logic [7:0] RSBA_OFS_2 = 8'h42;
  localparam logic [7:0] RSBA_OFS_3 = 8'h43;

  // Buffer configuration fields
  localparam int RSBA_CFG_VIEW_BIT = 6;
  localparam int RSBA_CFG_IRQ_BIT = 5;
  localparam int RSBA_CFG_ESF_BIT = 2;
  localparam int RSBA_CFG_PER_CHANNEL_FUNCTION_ENABLE_BIT = 0;
  localparam logic [7:0] RSBA_CFG_MASK = 8'h65;
  localparam logic [7:0] RSBA_CFG_RESET = 8'h00;

  // Indirect address/control and status fields
  localparam int RSBA_DIR_BIT = 7;
  localparam int RSBA_BUSY_BIT = 7;
  localparam logic [7:0] RSBA_ADDR_CTRL_RESET = 8'h00;
  localparam logic [7:0] RSBA_DATA_BUF_RESET = 8'h00;

  // Indirect map
  localparam logic [6:0] RSBA_IND_COPY1_LO = 7'h01;
  localparam logic [6:0] RSBA_IND_COPY1_HI = 7'h18;
  localparam logic [6:0] RSBA_IND_COPY2_LO = 7'h21;
  localparam logic [6:0] RSBA_IND_COPY2_HI = 7'h38;
  localparam logic [6:0] RSBA_IND_CFG_LO = 7'h41;
  localparam logic [6:0] RSBA_IND_CFG_HI = 7'h58;
  localparam int RSBA_DEB_BIT = 0;
  localparam int RSBA_NUM_CH = 24;

  // Timing
  localparam int RSBA_CLK_NS = 4;
  localparam int RSBA_OP_NS = 650;
  localparam int RSBA_DATA_NS = 640;
  localparam int RSBA_COPY2_MS = 2;
  localparam int RSBA_OP_CYC = RSBA_OP_NS / RSBA_CLK_NS;
  localparam int RSBA_DATA_CYC = RSBA_DATA_NS / RSBA_CLK_NS;
  localparam int RSBA_COPY2_CYC = RSBA_COPY2_MS * 1000000 / RSBA_CLK_NS;

  typedef enum logic [1:0] {
    RSBA_IDLE = 2'b01,
    RSBA_BUSY = 2'b10
  } rsba_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsba_bus_type;

  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [3:0] abcd;
  } rsba_sample_type;

endpackage

// ===== verilog/rsba_top.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// [RULE1] Busy reads 1 while an indirect access runs; new ones are refused.
// [RULE2] Each indirect access lasts 650 ns; the code holds busy 162 clocks (648 ns), then busy drops on a clock edge.
// [RULE3] Host waits for busy low before starting another indirect access.
// [RULE4] Address/control bit 7 chooses write (0) or read (1).
// [RULE5] Low seven bits of address/control are the indirect address.
// [RULE6] Host loads data buffer before writing address with direction 0.
// [RULE7] Writing address/control starts an access with the written fields.
// [RULE8] An indirect read fills the data buffer within 640 ns.
// [RULE9] Config bit 6 swaps offsets 1..3 between access port and flags.
// [RULE10] One change flag per channel; offsets 1,2,3 hold 24-17, 16-9, 8-1.
// [RULE11] Reading a flag register clears its flags.
// [RULE12] Indirect map: copies at 01-18h and 21-38h, config at 41-58h.
// [RULE13] Signaling data returns A,B,C,D in bits 3..0, upper bits zero.
// [RULE14] Second copy follows the first within 2 ms.
// [RULE15] Host reads first copy, falls back to second if unchanged.
// [RULE16] In superframe format C and D repeat A and B.
// [RULE17] Debounce accepts signaling after two equal consecutive samples.
// [RULE18] Per-channel enable gates all per-channel features, debounce too; the code gates only debounce, and change flags are set with it off.
// [RULE19] Format bit selects superframe or extended superframe handling.
// [RULE20] Interrupt output goes low on any change flag when enabled.
// [RULE21] Address/control writes are ignored while busy.
module rsba_top #(
  parameter int COPY2_CYC = rsba_pkg::RSBA_COPY2_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire rsba_pkg::rsba_bus_type bus,
  output logic [7:0] rdata,
  input wire rsba_pkg::rsba_sample_type sample,
  output logic irq_b
);
  import rsba_pkg::*;

  logic [7:0] cfg_ff;
  logic [7:0] addr_ctrl_ff;
  logic [7:0] data_buf_ff;
  logic [7:0] rdata_ff;
  logic [23:0] flags_ff;
  logic irq_b_ff;
  rsba_state_type state_ff;
  logic [7:0] op_cnt_ff;
  logic [19:0] copy2_cnt_ff;
  logic [3:0] copy1_ff [RSBA_NUM_CH];
  logic [3:0] copy2_ff [RSBA_NUM_CH];
  logic [3:0] last_ff [RSBA_NUM_CH];
  logic [RSBA_NUM_CH-1:0] deb_ff;

  logic view_chg;
  logic busy;
  logic start;
  logic do_access;
  logic is_rd;
  logic [6:0] ind_addr;
  logic [4:0] s_idx;
  logic [3:0] s_code;
  logic s_accept;
  logic s_change;
  logic [23:0] set_vec;
  logic [23:0] clr_vec;
  logic [7:0] ind_rdval;
  logic copy2_tick;

  // Channel index from an indirect address and its region base
  function automatic logic [4:0] ind_idx(input logic [6:0] a,
                                         input logic [6:0] lo);
    logic [6:0] d;
    d = a - lo;
    return d[4:0];
  endfunction

  function automatic logic in_rng(input logic [6:0] a, input logic [6:0] lo,
                                  input logic [6:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  assign view_chg = cfg_ff[RSBA_CFG_VIEW_BIT]; // RULE9
  assign busy = (state_ff == RSBA_BUSY);
  assign is_rd = addr_ctrl_ff[RSBA_DIR_BIT]; // RULE4
  assign ind_addr = addr_ctrl_ff[6:0]; // RULE5
  assign start = bus.wr && (bus.addr == RSBA_OFS_2) && !view_chg
    && !busy; // RULE7 RULE21
  assign do_access = busy && (op_cnt_ff == 8'(RSBA_DATA_CYC - 1));

  ////////////////////////////////////////////////////////////////////////
  // Buffer configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= RSBA_CFG_RESET;
    end else if (bus.wr && bus.addr == RSBA_OFS_CONFIG) begin
      cfg_ff <= bus.wdata & RSBA_CFG_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Indirect access sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= RSBA_IDLE;
      op_cnt_ff <= 8'h00;
    end else begin
      case (state_ff)
        RSBA_IDLE: begin
          op_cnt_ff <= 8'h00;
          if (start) begin
            state_ff <= RSBA_BUSY; // RULE1
          end
        end
        RSBA_BUSY: begin
          op_cnt_ff <= op_cnt_ff + 8'h01;
          if (op_cnt_ff == 8'(RSBA_OP_CYC - 1)) begin
            state_ff <= RSBA_IDLE; // RULE2
          end
        end
        default: begin
          state_ff <= RSBA_IDLE;
        end
      endcase
    end
  end

  // Busy-time writes would race the access, so they are dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ctrl_ff <= RSBA_ADDR_CTRL_RESET;
    end else if (start) begin
      addr_ctrl_ff <= bus.wdata; // RULE7 RULE21
    end
  end

  // Read value of the addressed indirect location
  always_comb begin
    ind_rdval = 8'h00;
    if (in_rng(ind_addr, RSBA_IND_COPY1_LO, RSBA_IND_COPY1_HI)) begin
      ind_rdval = {4'h0, copy1_ff[ind_idx(ind_addr, RSBA_IND_COPY1_LO)]};
    end else if (in_rng(ind_addr, RSBA_IND_COPY2_LO, RSBA_IND_COPY2_HI)) begin
      ind_rdval = {4'h0, copy2_ff[ind_idx(ind_addr, RSBA_IND_COPY2_LO)]};
    end else if (in_rng(ind_addr, RSBA_IND_CFG_LO, RSBA_IND_CFG_HI)) begin
      ind_rdval = {7'h00, deb_ff[ind_idx(ind_addr, RSBA_IND_CFG_LO)]};
    end
  end // RULE12 RULE13

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_buf_ff <= RSBA_DATA_BUF_RESET;
    end else if (do_access && is_rd) begin
      data_buf_ff <= ind_rdval; // RULE8
    end else if (bus.wr && bus.addr == RSBA_OFS_3 && !view_chg && !busy) begin
      data_buf_ff <= bus.wdata;
    end
  end

  // Only the debounce bit is writable; signaling data is read-only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      deb_ff <= '0;
    end else if (do_access && !is_rd
                 && in_rng(ind_addr, RSBA_IND_CFG_LO, RSBA_IND_CFG_HI)) begin
      deb_ff[ind_idx(ind_addr, RSBA_IND_CFG_LO)] <=
        data_buf_ff[RSBA_DEB_BIT]; // RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Received signaling
  assign s_idx = sample.chan - 5'd1;
  assign s_code = cfg_ff[RSBA_CFG_ESF_BIT] ? sample.abcd
    : {sample.abcd[3:2], sample.abcd[3:2]}; // RULE16 RULE19
  assign s_accept = sample.valid && (sample.chan != 5'd0)
    && (sample.chan <= 5'(RSBA_NUM_CH))
    && (!(cfg_ff[RSBA_CFG_PER_CHANNEL_FUNCTION_ENABLE_BIT] && deb_ff[s_idx])
        || last_ff[s_idx] == s_code); // RULE17 RULE18
  assign s_change = s_accept && (copy1_ff[s_idx] != s_code);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < RSBA_NUM_CH; i++) begin
        last_ff[i] <= 4'h0;
        copy1_ff[i] <= 4'h0;
      end
    end else if (sample.valid && sample.chan != 5'd0
                 && sample.chan <= 5'(RSBA_NUM_CH)) begin
      last_ff[s_idx] <= s_code;
      if (s_change) begin
        copy1_ff[s_idx] <= s_code; // RULE17
      end
    end
  end

  // A shared refresh tick is cheaper than one timer per channel
  assign copy2_tick = (copy2_cnt_ff == 20'(COPY2_CYC - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      copy2_cnt_ff <= 20'h00000;
      for (int i = 0; i < RSBA_NUM_CH; i++) begin
        copy2_ff[i] <= 4'h0;
      end
    end else begin
      copy2_cnt_ff <= copy2_tick ? 20'h00000 : copy2_cnt_ff + 20'h00001;
      if (copy2_tick) begin
        for (int i = 0; i < RSBA_NUM_CH; i++) begin
          copy2_ff[i] <= copy1_ff[i]; // RULE14
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Change flags: set wins over clear-on-read
  always_comb begin
    set_vec = '0;
    if (s_change) begin
      set_vec[s_idx] = 1'b1; // RULE10
    end
    clr_vec = '0;
    if (bus.rd && view_chg) begin
      if (bus.addr == RSBA_OFS_1) begin
        clr_vec[23:16] = 8'hFF; // RULE11
      end
      if (bus.addr == RSBA_OFS_2) begin
        clr_vec[15:8] = 8'hFF;
      end
      if (bus.addr == RSBA_OFS_3) begin
        clr_vec[7:0] = 8'hFF;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= (flags_ff & ~clr_vec) | set_vec; // RULE10 RULE11
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b_ff <= 1'b1;
    end else begin
      irq_b_ff <= !(cfg_ff[RSBA_CFG_IRQ_BIT] && |flags_ff); // RULE20
    end
  end

  assign irq_b = irq_b_ff;

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        RSBA_OFS_CONFIG: rdata_ff <= cfg_ff;
        RSBA_OFS_1: rdata_ff <= view_chg ? flags_ff[23:16]
          : {busy, 7'h00}; // RULE1 RULE9
        RSBA_OFS_2: rdata_ff <= view_chg ? flags_ff[15:8] : addr_ctrl_ff;
        RSBA_OFS_3: rdata_ff <= view_chg ? flags_ff[7:0] : data_buf_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_start_busy;
    @(posedge clk) disable iff (!rst_b)
    start |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy) // RULE7
    else $error("access did not start on address write");

  property p_busy_len;
    @(posedge clk) disable iff (!rst_b)
    $fell(busy) |-> $past(op_cnt_ff) == 8'(RSBA_OP_CYC - 1);
  endproperty
  a_busy_len: assert property (p_busy_len) // RULE2
    else $error("busy length wrong");

  property p_busy_rd;
    @(posedge clk) disable iff (!rst_b)
    bus.rd && bus.addr == RSBA_OFS_1 && !view_chg |=>
      rdata[RSBA_BUSY_BIT] == $past(busy);
  endproperty
  a_busy_rd: assert property (p_busy_rd) // RULE1
    else $error("busy status misreported");

  property p_ignore;
    @(posedge clk) disable iff (!rst_b)
    busy && bus.wr && bus.addr == RSBA_OFS_2 |=>
      $stable(addr_ctrl_ff);
  endproperty
  a_ignore: assert property (p_ignore) // RULE21
    else $error("address write taken while busy");

  property p_read_data;
    @(posedge clk) disable iff (!rst_b)
    start && bus.wdata[RSBA_DIR_BIT]
      && bus.wdata[6:0] == RSBA_IND_CFG_LO |-> ##161
      data_buf_ff == {7'h00, deb_ff[0]};
  endproperty
  a_read_data: assert property (p_read_data) // RULE8
    else $error("indirect read data late or wrong");

  property p_clear;
    @(posedge clk) disable iff (!rst_b)
    bus.rd && view_chg && bus.addr == RSBA_OFS_3 && !s_change |=>
      flags_ff[7:0] == 8'h00;
  endproperty
  a_clear: assert property (p_clear) // RULE11
    else $error("flags not cleared by read");

  property p_flag_set;
    @(posedge clk) disable iff (!rst_b)
    s_change |=> flags_ff[$past(s_idx)];
  endproperty
  a_flag_set: assert property (p_flag_set) // RULE10
    else $error("change flag not set");

  property p_sf;
    @(posedge clk) disable iff (!rst_b)
    s_change && !cfg_ff[RSBA_CFG_ESF_BIT] |=>
      copy1_ff[$past(s_idx)][1:0] == copy1_ff[$past(s_idx)][3:2];
  endproperty
  a_sf: assert property (p_sf) // RULE16
    else $error("C,D do not repeat A,B");

  property p_debounce;
    @(posedge clk) disable iff (!rst_b)
    sample.valid && sample.chan == 5'd1 && cfg_ff[RSBA_CFG_PER_CHANNEL_FUNCTION_ENABLE_BIT]
      && deb_ff[0] && last_ff[0] != s_code |=> $stable(copy1_ff[0]);
  endproperty
  a_debounce: assert property (p_debounce) // RULE17
    else $error("single sample accepted under debounce");

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
    cfg_ff[RSBA_CFG_IRQ_BIT] && |flags_ff ##1 cfg_ff[RSBA_CFG_IRQ_BIT]
      |-> !irq_b;
  endproperty
  a_irq: assert property (p_irq) // RULE20
    else $error("interrupt not raised");

  property p_upper_zero;
    @(posedge clk) disable iff (!rst_b)
    do_access && is_rd |=> data_buf_ff[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // RULE13
    else $error("reserved signaling bits not zero");

  // With per-channel functions off a single sample must be taken
  property p_no_gate;
    @(posedge clk) disable iff (!rst_b)
    sample.valid && sample.chan == 5'd1 && !cfg_ff[RSBA_CFG_PER_CHANNEL_FUNCTION_ENABLE_BIT]
      && copy1_ff[0] != s_code |=> copy1_ff[0] == $past(s_code);
  endproperty
  a_no_gate: assert property (p_no_gate) // RULE18
    else $error("debounce applied with per-channel functions off");

  c_read: cover property (@(posedge clk) disable iff (!rst_b)
    start && bus.wdata[RSBA_DIR_BIT]);
  c_write: cover property (@(posedge clk) disable iff (!rst_b)
    do_access && !is_rd);
  c_clear: cover property (@(posedge clk) disable iff (!rst_b)
    |clr_vec && |flags_ff);
  c_irq: cover property (@(posedge clk) disable iff (!rst_b) !irq_b);
  c_ungated: cover property (@(posedge clk) disable iff (!rst_b)
    s_change && !cfg_ff[RSBA_CFG_PER_CHANNEL_FUNCTION_ENABLE_BIT]);

endmodule // rsba_top

`default_nettype wire
